// file: verilog/pbh_map.svh
// constants for the power button input handler: times, codes, counts
// assumes a 200 MHz system clock; long counts are scaled by module parameters
`ifndef PBH_MAP_SVH
`define PBH_MAP_SVH

`define PBH_CLK_MHZ 200
`define PBH_US_PER_MS 1000
`define PBH_MS_PER_S 1000
`define PBH_CYC_PER_MS (`PBH_CLK_MHZ * `PBH_US_PER_MS)

`define PBH_DBNC_SHORT_MS 32
`define PBH_DBNC_MID_MS 125
`define PBH_DBNC_LONG_MS 750
`define PBH_DBNC_RISE_MS `PBH_DBNC_SHORT_MS

`define PBH_HOLD_1_S 1
`define PBH_HOLD_2_S 2
`define PBH_HOLD_3_S 3
`define PBH_HOLD_4_S 4
`define PBH_HOLD_8_S 8

`define PBH_LP_00_S 2
`define PBH_LP_01_S 4
`define PBH_LP_10_S 8
`define PBH_LP_11_S 16

`define PBH_DISCHARGE_US 30
`define PBH_DISCHARGE_CYC (`PBH_DISCHARGE_US * `PBH_CLK_MHZ)

`define PBH_CODE_00 2'h0
`define PBH_CODE_01 2'h1
`define PBH_CODE_10 2'h2
`define PBH_CODE_11 2'h3

`define PBH_MODE_LEVEL 1'h0
`define PBH_MODE_EDGE 1'h1

`define PBH_HOLD_MAX_MS 14'h3FFF
`define PBH_FLAGS_NONE 7'h00
`define PBH_DBNC_SEL_RST 2'h0
`define PBH_LP_SEL_RST 2'h0

`endif

// file: verilog/pbh_pkg.sv
// types shared by the power button input handler modules
// constants live in pbh_map.svh
package pbh_pkg;

   typedef struct packed {
      logic hold_8s_flag;
      logic hold_4s_flag;
      logic hold_3s_flag;
      logic hold_2s_flag;
      logic hold_1s_flag;
      logic release_event_flag;
      logic press_event_flag;
   } pbh_flags_t;

   typedef enum logic [1:0] {
      PBH_SEQ_IDLE = 2'b00,
      PBH_SEQ_PDOWN = 2'b01,
      PBH_SEQ_DISCHARGE = 2'b10
   } pbh_seq_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } pbh_tick_t;

   typedef struct packed {
      logic [2:0] sync;
      logic pin;
      logic deb;
      logic [9:0] dbnc_ms;
      logic [13:0] hold_ms;
      pbh_flags_t flags;
      logic [1:0] dbnc_sel;
      logic [1:0] lp_sel;
      logic otp_load;
      pbh_seq_t seq;
      logic [15:0] dis_cnt;
      logic pon_evt;
      logic turn_off;
      logic pup;
      logic reload;
   } pbh_core_t;

endpackage : pbh_pkg

// file: verilog/pbh_tick.sv
// millisecond time base for the power button input handler
// runs on the system clock; reset is the already synchronised copy
`timescale 1ns/1ps
`include "pbh_map.svh"
module pbh_tick #(
   parameter int unsigned P_MS_CYC = `PBH_CYC_PER_MS
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   output logic o_ms_tick
);
   import pbh_pkg::*;

   pbh_tick_t q;
   pbh_tick_t d;

   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == 32'(P_MS_CYC - 1))
      begin
         d.cnt = 32'h0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_ms_tick = q.tick;

endmodule : pbh_tick

// file: verilog/pbh_top.sv
// power button input handler: pin sync, debounce, hold timers, long press action
// power sequencer, OTP bits and flag clearing sit outside and reach it by plain ports
`timescale 1ns/1ps
`include "pbh_map.svh"
module pbh_top #(
   parameter int unsigned P_MS_CYC = `PBH_CYC_PER_MS,
   parameter int unsigned P_DISCHARGE_CYC = `PBH_DISCHARGE_CYC
)(
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_power_on_input,
   input wire logic i_otp_input_mode_select,
   input wire logic [1:0] i_otp_debounce_default,
   input wire logic [1:0] i_otp_long_press_default,
   input wire logic i_long_press_reset_enable,
   input wire logic i_debounce_select_we,
   input wire logic [1:0] i_debounce_select_wdata,
   input wire logic i_long_press_time_select_we,
   input wire logic [1:0] i_long_press_time_select_wdata,
   input wire pbh_pkg::pbh_flags_t i_flag_clear,
   input wire logic i_system_on,
   input wire logic i_power_down_done,
   output logic o_button_level_sense,
   output logic o_power_on_allow,
   output logic o_power_on_event,
   output pbh_pkg::pbh_flags_t o_flags,
   output logic [1:0] o_debounce_select,
   output logic [1:0] o_long_press_time_select,
   output logic o_power_down_req,
   output logic o_power_up_req,
   output logic o_otp_reload,
   output logic o_turn_off_event,
   output logic o_reset_busy
);
   import pbh_pkg::*;

   // falling debounce length in ms for a select code
   function automatic logic [9:0] dbnc_fall_ms(input logic [1:0] sel);
      logic [9:0] ms;
      ms = 10'(`PBH_DBNC_SHORT_MS);
      unique case (sel)
         `PBH_CODE_00: ms = 10'(`PBH_DBNC_SHORT_MS);
         `PBH_CODE_01: ms = 10'(`PBH_DBNC_SHORT_MS);
         `PBH_CODE_10: ms = 10'(`PBH_DBNC_MID_MS);
         `PBH_CODE_11: ms = 10'(`PBH_DBNC_LONG_MS);
      endcase
      return ms;
   endfunction : dbnc_fall_ms

   // long press time in ms for a select code
   function automatic logic [13:0] lp_ms(input logic [1:0] sel);
      logic [13:0] ms;
      ms = 14'(`PBH_LP_00_S * `PBH_MS_PER_S);
      unique case (sel)
         `PBH_CODE_00: ms = 14'(`PBH_LP_00_S * `PBH_MS_PER_S);
         `PBH_CODE_01: ms = 14'(`PBH_LP_01_S * `PBH_MS_PER_S);
         `PBH_CODE_10: ms = 14'(`PBH_LP_10_S * `PBH_MS_PER_S);
         `PBH_CODE_11: ms = 14'(`PBH_LP_11_S * `PBH_MS_PER_S);
      endcase
      return ms;
   endfunction : lp_ms

   // seconds to a hold count in ms
   function automatic logic [13:0] sec_ms(input int unsigned s);
      return 14'(s * `PBH_MS_PER_S);
   endfunction : sec_ms

   // mode decode shared by the pin filter and the power-on gate
   function automatic logic is_edge_mode(input logic mode);
      return (mode == `PBH_MODE_EDGE);
   endfunction : is_edge_mode

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic ms_tick;
   pbh_core_t q;
   pbh_core_t d;

   // release of reset is synchronised; assertion stays asynchronous
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   pbh_tick #(
      .P_MS_CYC(P_MS_CYC)
   ) pbh_tick_inst (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .o_ms_tick(ms_tick)
   );

   always_comb
   begin
      logic edge_mode;
      logic fell;
      logic rose;
      logic adv;
      logic [13:0] hold_nxt;
      logic [9:0] thr;
      pbh_flags_t set;
      edge_mode = is_edge_mode(i_otp_input_mode_select);
      fell = 1'b0;
      rose = 1'b0;
      adv = 1'b0;
      hold_nxt = q.hold_ms + 14'h1;
      thr = q.pin ? 10'(`PBH_DBNC_RISE_MS) : dbnc_fall_ms(q.dbnc_sel);
      set = `PBH_FLAGS_NONE;

      d = q;
      d.pon_evt = 1'b0;
      d.turn_off = 1'b0;
      d.pup = 1'b0;
      d.reload = 1'b0;

      // a pin level counts only once the second and third stages agree
      d.sync = {q.sync[1], q.sync[0], i_power_on_input};
      if (q.sync[1] == q.sync[2])
      begin
         d.pin = q.sync[2];
      end

      // OTP defaults land one cycle after reset release or a forced reset
      if (q.otp_load)
      begin
         d.dbnc_sel = i_otp_debounce_default;
         d.lp_sel = i_otp_long_press_default;
         d.otp_load = 1'b0;
      end
      else
      begin
         if (i_debounce_select_we)
         begin
            d.dbnc_sel = i_debounce_select_wdata;
         end
         if (i_long_press_time_select_we)
         begin
            d.lp_sel = i_long_press_time_select_wdata;
         end
      end

      if (!edge_mode)
      begin
         // level mode: no debounce, the filtered level is used as is
         d.deb = q.pin;
         d.dbnc_ms = 10'h0;
         rose = q.pin & ~q.deb;
      end
      else if (q.pin == q.deb)
      begin
         d.dbnc_ms = 10'h0;
      end
      else if (ms_tick)
      begin
         // flips one tick after reaching the time, so the level held longer than it
         if (q.dbnc_ms == thr)
         begin
            d.deb = q.pin;
            d.dbnc_ms = 10'h0;
            fell = ~q.pin;
            rose = q.pin;
         end
         else
         begin
            d.dbnc_ms = q.dbnc_ms + 10'h1;
         end
      end

      // hold timer counts only while the debounced button is pressed
      // saturates, so a stuck button never wraps into a second long press
      if (!edge_mode || q.deb)
      begin
         d.hold_ms = 14'h0;
      end
      else if (ms_tick && q.hold_ms != `PBH_HOLD_MAX_MS)
      begin
         adv = 1'b1;
         d.hold_ms = hold_nxt;
      end

      if (edge_mode && i_system_on)
      begin
         set.press_event_flag = fell;
         set.release_event_flag = rose;
      end
      if (adv)
      begin
         set.hold_1s_flag = (hold_nxt == sec_ms(`PBH_HOLD_1_S));
         set.hold_2s_flag = (hold_nxt == sec_ms(`PBH_HOLD_2_S));
         set.hold_3s_flag = (hold_nxt == sec_ms(`PBH_HOLD_3_S));
         set.hold_4s_flag = (hold_nxt == sec_ms(`PBH_HOLD_4_S));
         set.hold_8s_flag = (hold_nxt == sec_ms(`PBH_HOLD_8_S));
      end
      // a set in the same cycle as its clear wins
      d.flags = (q.flags & ~i_flag_clear) | set;

      // power-on request only matters while the system is off
      if (!i_system_on)
      begin
         d.pon_evt = edge_mode ? fell : rose;
      end

      unique case (q.seq)
         PBH_SEQ_IDLE:
         begin
            d.dis_cnt = 16'h0;
            // equality match: one action per press, none while busy
            if (adv && hold_nxt == lp_ms(q.lp_sel))
            begin
               if (i_long_press_reset_enable)
               begin
                  d.seq = PBH_SEQ_PDOWN;
               end
               else
               begin
                  d.turn_off = 1'b1;
               end
            end
         end
         PBH_SEQ_PDOWN:
         begin
            d.dis_cnt = 16'h0;
            // no timeout: waits as long as the sequencer takes
            if (i_power_down_done)
            begin
               d.seq = PBH_SEQ_DISCHARGE;
            end
         end
         PBH_SEQ_DISCHARGE:
         begin
            if (q.dis_cnt == 16'(P_DISCHARGE_CYC - 1))
            begin
               // supplies have discharged: power back up on OTP defaults
               d.seq = PBH_SEQ_IDLE;
               d.pup = 1'b1;
               d.reload = 1'b1;
               d.otp_load = 1'b1;
               d.dis_cnt = 16'h0;
            end
            else
            begin
               d.dis_cnt = q.dis_cnt + 16'h1;
            end
         end
         default:
         begin
            d.seq = PBH_SEQ_IDLE;
            d.dis_cnt = 16'h0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // filter starts at released: no false press after reset
         q.sync <= 3'h7;
         q.pin <= 1'b1;
         q.deb <= 1'b1;
         q.dbnc_ms <= 10'h0;
         q.hold_ms <= 14'h0;
         q.flags <= `PBH_FLAGS_NONE;
         q.dbnc_sel <= `PBH_DBNC_SEL_RST;
         q.lp_sel <= `PBH_LP_SEL_RST;
         q.otp_load <= 1'b1;
         q.seq <= PBH_SEQ_IDLE;
         q.dis_cnt <= 16'h0;
         q.pon_evt <= 1'b0;
         q.turn_off <= 1'b0;
         q.pup <= 1'b0;
         q.reload <= 1'b0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_button_level_sense = ~q.pin;
   // level mode blocks power-up while the pin is low
   assign o_power_on_allow = is_edge_mode(i_otp_input_mode_select) | q.pin;
   assign o_power_on_event = q.pon_evt;
   assign o_flags = q.flags;
   assign o_debounce_select = q.dbnc_sel;
   assign o_long_press_time_select = q.lp_sel;
   assign o_power_down_req = (q.seq == PBH_SEQ_PDOWN);
   assign o_power_up_req = q.pup;
   assign o_otp_reload = q.reload;
   assign o_turn_off_event = q.turn_off;
   assign o_reset_busy = (q.seq != PBH_SEQ_IDLE);

endmodule : pbh_top

// file: testbench/pbh_top_sva.sv
// checker for pbh_top, sees only its ports
// bound below; one clock, one reset
`timescale 1ns/1ps
`include "pbh_map.svh"
module pbh_top_sva #(
   parameter int unsigned P_DISCHARGE_CYC = `PBH_DISCHARGE_CYC
)(
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_power_on_input,
   input wire logic i_otp_input_mode_select,
   input wire logic [1:0] i_otp_debounce_default,
   input wire logic [1:0] i_otp_long_press_default,
   input wire logic i_long_press_reset_enable,
   input wire logic i_debounce_select_we,
   input wire logic [1:0] i_debounce_select_wdata,
   input wire pbh_pkg::pbh_flags_t i_flag_clear,
   input wire logic i_system_on,
   input wire logic i_power_down_done,
   input wire logic o_button_level_sense,
   input wire logic o_power_on_allow,
   input wire pbh_pkg::pbh_flags_t o_flags,
   input wire logic [1:0] o_debounce_select,
   input wire logic [1:0] o_long_press_time_select,
   input wire logic o_power_down_req,
   input wire logic o_power_up_req,
   input wire logic o_otp_reload,
   input wire logic o_turn_off_event,
   input wire logic o_reset_busy
);
   import pbh_pkg::*;
   logic [15:0] dis_q;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // nine samples cover sync chain plus reset release
   property p_sense; (!i_power_on_input) [*8] |=> o_button_level_sense; endproperty
   a_sense: assert property (p_sense) else $error("sense not set on low pin");
   property p_lvl; (!i_otp_input_mode_select && !i_power_on_input) [*8] |=> !o_power_on_allow; endproperty
   a_lvl: assert property (p_lvl) else $error("level mode allows power on while low");
   property p_edge; i_otp_input_mode_select |-> o_power_on_allow; endproperty
   a_edge: assert property (p_edge) else $error("edge mode blocks power on");
   property p_hold; 1 |=> (($past(o_flags) & ~$past(i_flag_clear)) & ~o_flags) == 7'h00; endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without clear");
   property p_press; $rose(o_flags.press_event_flag) |-> $past(i_system_on); endproperty
   a_press: assert property (p_press) else $error("press flag while system off");
   property p_lp_rst; $rose(o_power_down_req) |-> $past(i_long_press_reset_enable) && o_reset_busy; endproperty
   a_lp_rst: assert property (p_lp_rst) else $error("reset without enable");
   property p_toff; o_turn_off_event |-> !$past(i_long_press_reset_enable) ##1 !o_turn_off_event; endproperty
   a_toff: assert property (p_toff) else $error("bad turn off pulse");
   // discharge cycles seen so far; a delay range could not reach the real count
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         dis_q <= 16'h0;
      else if (o_reset_busy && !o_power_down_req)
         dis_q <= dis_q + 16'h1;
      else
         dis_q <= 16'h0;
   end
   // assumes a discharge of at least eight cycles
   sequence s_dis;
      (!o_power_down_req && o_reset_busy && !o_power_up_req) [*8];
   endsequence
   sequence s_pup;
      o_otp_reload && !o_reset_busy && dis_q == 16'(P_DISCHARGE_CYC);
   endsequence
   property p_dis; o_power_down_req && i_power_down_done |=> s_dis; endproperty
   a_dis: assert property (p_dis) else $error("discharge wait wrong");
   property p_pup; o_power_up_req |-> s_pup; endproperty
   a_pup: assert property (p_pup) else $error("power up before discharge ends");
   property p_reload;
      o_otp_reload |=> o_debounce_select == $past(i_otp_debounce_default)
         && o_long_press_time_select == $past(i_otp_long_press_default);
   endproperty
   a_reload: assert property (p_reload) else $error("defaults not reloaded");
   property p_sel; i_debounce_select_we && !o_otp_reload |=> o_debounce_select == $past(i_debounce_select_wdata); endproperty
   a_sel: assert property (p_sel) else $error("debounce select not written");
endmodule : pbh_top_sva
bind pbh_top pbh_top_sva #(.P_DISCHARGE_CYC(P_DISCHARGE_CYC)) pbh_top_sva_inst (.i_sys_clk, .i_reset_n,
   .i_power_on_input, .i_otp_input_mode_select, .i_otp_debounce_default, .i_otp_long_press_default,
   .i_long_press_reset_enable, .i_debounce_select_we, .i_debounce_select_wdata, .i_flag_clear, .i_system_on,
   .i_power_down_done, .o_button_level_sense, .o_power_on_allow, .o_flags, .o_debounce_select,
   .o_long_press_time_select, .o_power_down_req, .o_power_up_req, .o_otp_reload, .o_turn_off_event, .o_reset_busy);

// file: testbench/pbh_button.sv
// push button with pull-up to the input supply
// the pin is never left floating: pull-up when open
`timescale 1ns/1ps
module pbh_button (
   input wire logic i_pressed,
   output logic o_pin
);
   assign o_pin = i_pressed ? 1'b0 : 1'b1;
endmodule : pbh_button

// file: testbench/pbh_top_bench.sv
// bench for pbh_top with button model; bench acts as sequencer
// ms scaled to 2 cycles, discharge to 20 cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pbh_top_bench;
   import pbh_pkg::*;
   logic clk = 0, rst_n = 0, pressed = 0, pin, mode = 0, lp_en = 0, dwe = 0, lwe = 0, son = 0, pdd = 0;
   logic [1:0] dwd = 2'h0, lwd = 2'h0, otp_d = 2'h2, otp_l = 2'h1, dsel, lsel;
   pbh_flags_t clr = '0, flags;
   logic sense, allow, pon, pdr, pur, rel, toff, busy;
   int fails = 0, tests_run = 0, n_off = 0, n_pon = 0, k;
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      n_off += (toff === 1'b1);
      n_pon += (pon === 1'b1);
   end
   pbh_button pbh_button_inst (.i_pressed(pressed), .o_pin(pin));
   pbh_top #(.P_MS_CYC(2), .P_DISCHARGE_CYC(20)) pbh_top_inst (.i_sys_clk(clk), .i_reset_n(rst_n),
      .i_power_on_input(pin), .i_otp_input_mode_select(mode), .i_otp_debounce_default(otp_d),
      .i_otp_long_press_default(otp_l), .i_long_press_reset_enable(lp_en), .i_debounce_select_we(dwe),
      .i_debounce_select_wdata(dwd), .i_long_press_time_select_we(lwe), .i_long_press_time_select_wdata(lwd),
      .i_flag_clear(clr), .i_system_on(son), .i_power_down_done(pdd), .o_button_level_sense(sense),
      .o_power_on_allow(allow), .o_power_on_event(pon), .o_flags(flags), .o_debounce_select(dsel),
      .o_long_press_time_select(lsel), .o_power_down_req(pdr), .o_power_up_req(pur), .o_otp_reload(rel),
      .o_turn_off_event(toff), .o_reset_busy(busy));
   // ends 1 ns after an edge so checks see settled registers
   task wt(input int ms);
      repeat (2 * ms) @(posedge clk);
      #1;
   endtask : wt
   task t_reset;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      wt(4);
      `CHK("dsel", otp_d, dsel)
      `CHK("lsel", otp_l, lsel)
      `CHK("flags", 7'h00, flags)
   endtask : t_reset
   task t_level;
      @(posedge clk) pressed <= 1;
      wt(5);
      `CHK("allow lo", 1'b0, allow)
      @(posedge clk) pressed <= 0;
      wt(5);
      `CHK("allow hi", 1'b1, allow)
      `CHK("pon", 1, n_pon)
      `CHK("sense", 1'b0, sense)
   endtask : t_level
   task t_press;
      @(posedge clk) {mode, son, dwe, dwd} <= {3'b111, 2'h2};
      @(posedge clk) {dwe, pressed} <= 2'b01;
      wt(20);
      @(posedge clk) pressed <= 0;
      wt(40);
      `CHK("glitch", 1'b0, flags.press_event_flag)
      @(posedge clk) pressed <= 1;
      wt(122);
      `CHK("press early", 1'b0, flags.press_event_flag)
      `CHK("sense", 1'b1, sense)
      wt(6);
      `CHK("press", 1'b1, flags.press_event_flag)
      @(posedge clk) pressed <= 0;
      wt(29);
      `CHK("rel early", 1'b0, flags.release_event_flag)
      wt(6);
      `CHK("rel", 1'b1, flags.release_event_flag)
      @(posedge clk) clr <= 7'h03;
      @(posedge clk) clr <= 7'h00;
      #1;
      `CHK("clear", 7'h00, flags)
      // longest falling debounce with system off: event instead of flag
      @(posedge clk) {dwe, dwd, son, pressed} <= {1'b1, 2'h3, 1'b0, 1'b1};
      @(posedge clk) dwe <= 0;
      wt(748);
      `CHK("pon early", 1, n_pon)
      `CHK("allow edge", 1'b1, allow)
      wt(6);
      `CHK("pon edge", 2, n_pon)
      `CHK("no press off", 1'b0, flags.press_event_flag)
      @(posedge clk) {son, pressed} <= 2'h2;
      wt(40);
      `CHK("rise 32", 1'b1, flags.release_event_flag)
   endtask : t_press
   task t_hold;
      @(posedge clk) {dwe, dwd, lwe, lwd, pressed} <= {1'b1, 2'h0, 1'b1, 2'h1, 1'b1};
      @(posedge clk) {dwe, lwe} <= 2'b00;
      wt(1020);
      `CHK("1s early", 1'b0, flags.hold_1s_flag)
      wt(22);
      `CHK("1s", 1'b1, flags.hold_1s_flag)
      `CHK("off early", 0, n_off)
      wt(3018);
      `CHK("off", 1, n_off)
      wt(4000);
      `CHK("hold", 5'h1F, flags[6:2])
      `CHK("off once", 1, n_off)
      `CHK("no rst", 1'b0, pdr)
      @(posedge clk) {pressed, clr} <= {1'b0, 7'h7F};
      @(posedge clk) clr <= 7'h00;
      wt(40);
   endtask : t_hold
   task t_lprst;
      @(posedge clk) {lp_en, lwe, lwd, pressed} <= {2'b11, 2'h0, 1'b1};
      @(posedge clk) lwe <= 0;
      wt(2010);
      `CHK("rst early", 1'b0, pdr)
      for (k = 0; k < 200 && pdr !== 1'b1; k++) wt(1);
      `CHK("pdown", 1'b1, pdr)
      `CHK("busy", 1'b1, busy)
      wt(3);
      @(posedge clk) pdd <= 1;
      @(posedge clk) pdd <= 0;
      for (k = 0; k < 100 && pur !== 1'b1; k++) @(posedge clk) #1;
      `CHK("pup", 1'b1, rel)
      `CHK("pup req", 1'b1, pur)
      `CHK("idle", 1'b0, busy)
      @(posedge clk) pressed <= 0;
      #1;
      `CHK("dsel otp", otp_d, dsel)
      `CHK("lsel otp", otp_l, lsel)
   endtask : t_lprst
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial
   begin
      t_reset();
      t_level();
      t_press();
      t_hold();
      t_lprst();
      final_report();
   end
   // tests take about 22400 cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule : pbh_top_bench
